// ### clk_irq_ctrl.sv
// Purpose: Clock control, register window and event aggregation of a disc decoder
// Assumes: clk is the multiplied crystal clock; slower clocks are enables and levels
// Notes:   Host reaches registers through a plain strobe port with one-cycle read data
//
// Overview of operation
// - Multiplied crystal clock is fixed at 67.7376 MHz, eight times crystal.
// - Crystal halving select divides a 16.9344 MHz crystal by two first.
// - Core clock is multiplied clock halved, 50 % duty, further divided by field.
// - Core clock setup holds a sleep control that stops most clocks.
// - RF loop lock needed only for bit-rate to core ratio 0.25 to 2.
// - Serial-audio logic runs on bit clock, which is also driven out.
// - One bit divider register holds ratio and gating enable.
// - S/PDIF output enabled only during audio slave mode.
// - RF sample clock runs at 67.7376 MHz and captures converter samples.
// - External bit clock replaces internal one when serial setup selects input.
// - Debug monitor and external converter clocks set by one auxiliary register.
// - Each 8-bit register sits in a 32-bit slot, upper 24 bits zero.
// - Window spans 000h to 374h, own registers to 24Ch, others from 2A0h.
// - Latched event flags set by hardware, cleared by reading them.
// - Live event flags follow their sources two cycles later, without latching.
// - Every event flag has its own independently writable enable bit.
// - Interrupt output low when any flag and its enable are both set.
// - Masked flags still behave normally and can be polled.
// - Core divider offers factors 2, 4, 8, 16 and 32.
//
// The register offsets and the strobed register port were left to the implementer.
module clk_irq_ctrl #(
   parameter int ev_w = 8
) (
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst_b,
   // Register port
   input  wire logic [9:0]      addr,
   input  wire logic [31:0]     wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   output logic      [31:0]     rdata,
   // Event sources
   input  wire logic [ev_w-1:0] latched_src,
   input  wire logic [ev_w-1:0] live_src,
   // Converter samples
   input  wire logic [5:0]      rf_sample,
   output logic      [5:0]      rf_sample_q,
   // Derived clock enables
   output logic                 core_en,
   output logic                 audio_en,
   output logic                 spdif_en,
   output logic                 rf_sample_clock_en,
   // Output clock levels
   output logic                 bit_clk_out,
   output logic                 spdif_enable,
   output logic                 debug_monitor_clock,
   output logic                 external_dac_clock,
   output logic                 crystal_halving_select,
   // External bit clock pin
   input  wire logic            bit_clk_in,
   // Interrupt
   output logic                 irq_b
);
   logic [7:0]      core_setup_r;
   logic [7:0]      bit_setup_r;
   logic [7:0]      spdif_setup_r;
   logic [7:0]      aux_setup_r;
   logic [7:0]      serial_setup_r;
   logic [7:0]      analog_mult_r;
   logic [ev_w-1:0] latched_flags_r;
   logic [ev_w-1:0] latched_mask_r;
   logic [ev_w-1:0] live_mask_r;
   logic [ev_w-1:0] live_s1_r;
   logic [ev_w-1:0] live_flags_r;
   logic [ev_w-1:0] latch_s1_r;
   logic [ev_w-1:0] latch_s2_r;
   logic [31:0]     rdata_r;
   logic [31:0]     rdata_nxt;
   logic [2:0]      core_sel_r;
   logic            core_half_r;
   logic [4:0]      core_cnt_r;
   logic [4:0]      core_lim;
   logic            core_en_r;
   logic            sleep;
   logic            bclk_s1_r;
   logic            bclk_s2_r;
   logic            bclk_s3_r;
   logic            ext_tick;
   logic [5:0]      rf_q_r;

   clk_div_if bit_if ();
   clk_div_if spd_if ();
   clk_div_if mon_if ();
   clk_div_if dac_if ();

   // Sleep stops the derived domains, the RF capture keeps running
   assign sleep = core_setup_r[clk_ctrl_pkg::sleep_bit];

   // Core divide: 2 from the half-rate toggle, times 1..16 more
   always_comb begin
      case (core_sel_r)
         3'h0:    core_lim = 5'h00;
         3'h1:    core_lim = 5'h01;
         3'h2:    core_lim = 5'h03;
         3'h3:    core_lim = 5'h07;
         3'h4:    core_lim = 5'h0f;
         default: core_lim = 5'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_half_r <= 1'b0;
         core_cnt_r  <= 5'h00;
         core_en_r   <= 1'b0;
         core_sel_r  <= 3'h0;
      end else begin
         core_en_r   <= 1'b0;
         core_half_r <= !core_half_r;
         if (core_half_r) begin
            if (core_cnt_r >= core_lim) begin
               core_cnt_r <= 5'h00;
               core_en_r  <= !sleep;
               // Ratio change only at a period boundary
               if (core_setup_r[2:0] <= clk_ctrl_pkg::core_max_sel) begin
                  core_sel_r <= core_setup_r[2:0];
               end
            end else begin
               core_cnt_r <= core_cnt_r + 5'h01;
            end
         end
      end
   end
   assign core_en = core_en_r;

   // Bit clock, S/PDIF and auxiliary dividers
   assign bit_if.ratio = bit_setup_r[clk_ctrl_pkg::div_w-1:0];
   assign bit_if.run   = !sleep && !(bit_setup_r[clk_ctrl_pkg::gate_bit] && bit_clk_in_sel());
   assign spd_if.ratio = spdif_setup_r[clk_ctrl_pkg::div_w-1:0];
   assign spd_if.run   = !sleep && serial_setup_r[clk_ctrl_pkg::slave_bit];
   assign mon_if.ratio = {3'h0, aux_setup_r[3:0]};
   assign mon_if.run   = !sleep;
   assign dac_if.ratio = {3'h0, aux_setup_r[7:4]};
   assign dac_if.run   = !sleep;

   function automatic logic bit_clk_in_sel();
      bit_clk_in_sel = serial_setup_r[clk_ctrl_pkg::bclk_in_bit];
   endfunction : bit_clk_in_sel

   clk_div u_bit (.clk(clk), .rst_b(rst_b), .src_en(1'b1), .d(bit_if.div));
   clk_div u_spd (.clk(clk), .rst_b(rst_b), .src_en(1'b1), .d(spd_if.div));
   clk_div u_mon (.clk(clk), .rst_b(rst_b), .src_en(1'b1), .d(mon_if.div));
   clk_div u_dac (.clk(clk), .rst_b(rst_b), .src_en(1'b1), .d(dac_if.div));

   // External bit clock: synchronise, then rising edge detect
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bclk_s1_r <= 1'b0;
         bclk_s2_r <= 1'b0;
         bclk_s3_r <= 1'b0;
      end else begin
         bclk_s1_r <= bit_clk_in;
         bclk_s2_r <= bclk_s1_r;
         bclk_s3_r <= bclk_s2_r;
      end
   end
   assign ext_tick = bclk_s2_r && !bclk_s3_r;

   assign audio_en    = bit_clk_in_sel() ? (ext_tick && !sleep) : bit_if.tick;
   assign bit_clk_out = bit_clk_in_sel() ? 1'b0 : bit_if.level;
   assign spdif_en    = spd_if.tick;
   assign spdif_enable = serial_setup_r[clk_ctrl_pkg::slave_bit];
   assign debug_monitor_clock = mon_if.level;
   assign external_dac_clock  = dac_if.level;
   assign crystal_halving_select = analog_mult_r[clk_ctrl_pkg::halve_bit];

   // RF sample capture on every multiplied clock cycle
   assign rf_sample_clock_en = 1'b1;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rf_q_r <= 6'h00;
      end else begin
         rf_q_r <= rf_sample;
      end
   end
   assign rf_sample_q = rf_q_r;

   // Register writes
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_setup_r   <= clk_ctrl_pkg::core_setup_rst;
         bit_setup_r    <= clk_ctrl_pkg::bit_setup_rst;
         spdif_setup_r  <= clk_ctrl_pkg::spdif_setup_rst;
         aux_setup_r    <= clk_ctrl_pkg::aux_setup_rst;
         serial_setup_r <= clk_ctrl_pkg::zero8;
         analog_mult_r  <= clk_ctrl_pkg::zero8;
         latched_mask_r <= '0;
         live_mask_r    <= '0;
      end else if (wr) begin
         case (addr)
            clk_ctrl_pkg::core_setup_a:   core_setup_r   <= wdata[7:0];
            clk_ctrl_pkg::bit_setup_a:    bit_setup_r    <= wdata[7:0];
            clk_ctrl_pkg::spdif_setup_a:  spdif_setup_r  <= wdata[7:0];
            clk_ctrl_pkg::aux_setup_a:    aux_setup_r    <= wdata[7:0];
            clk_ctrl_pkg::serial_setup_a: serial_setup_r <= wdata[7:0];
            clk_ctrl_pkg::analog_mult_a:  analog_mult_r  <= wdata[7:0];
            clk_ctrl_pkg::latched_mask_a: latched_mask_r <= wdata[ev_w-1:0];
            clk_ctrl_pkg::live_mask_a:    live_mask_r    <= wdata[ev_w-1:0];
            default:                      ;
         endcase
      end
   end

   // Event inputs come from other logic domains: two stages each
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_s1_r   <= '0;
         latch_s2_r   <= '0;
         live_s1_r    <= '0;
         live_flags_r <= '0;
      end else begin
         latch_s1_r   <= latched_src;
         latch_s2_r   <= latch_s1_r;
         live_s1_r    <= live_src;
         live_flags_r <= live_s1_r;
      end
   end

   // Sticky flags; a new event wins over the read clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latched_flags_r <= '0;
      end else if (rd && addr == clk_ctrl_pkg::latched_flags_a) begin
         latched_flags_r <= latch_s2_r;
      end else begin
         latched_flags_r <= latched_flags_r | latch_s2_r;
      end
   end

   // Read data, upper 24 bits zero, unmapped reads zero
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (addr)
         clk_ctrl_pkg::core_setup_a:    rdata_nxt[7:0] = core_setup_r;
         clk_ctrl_pkg::bit_setup_a:     rdata_nxt[7:0] = bit_setup_r;
         clk_ctrl_pkg::spdif_setup_a:   rdata_nxt[7:0] = spdif_setup_r;
         clk_ctrl_pkg::aux_setup_a:     rdata_nxt[7:0] = aux_setup_r;
         clk_ctrl_pkg::serial_setup_a:  rdata_nxt[7:0] = serial_setup_r;
         clk_ctrl_pkg::analog_mult_a:   rdata_nxt[7:0] = analog_mult_r;
         clk_ctrl_pkg::latched_flags_a: rdata_nxt[ev_w-1:0] = latched_flags_r;
         clk_ctrl_pkg::live_flags_a:    rdata_nxt[ev_w-1:0] = live_flags_r;
         clk_ctrl_pkg::latched_mask_a:  rdata_nxt[ev_w-1:0] = latched_mask_r;
         clk_ctrl_pkg::live_mask_a:     rdata_nxt[ev_w-1:0] = live_mask_r;
         clk_ctrl_pkg::clk_status_a:    rdata_nxt[3:0] = {core_sel_r, sleep};
         default:                       rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 32'h0000_0000;
      end else if (rd && addr <= clk_ctrl_pkg::win_last_a) begin
         rdata_r <= rdata_nxt;
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end
   assign rdata = rdata_r;

   // Active-low interrupt from enabled flags
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_b <= 1'b1;
      end else begin
         irq_b <= !(|(latched_flags_r & latched_mask_r) ||
                    |(live_flags_r & live_mask_r));
      end
   end
endmodule : clk_irq_ctrl

// ### clk_ctrl_pkg.sv
// Purpose: Shared constants for the disc decoder clock and event control block
// Assumes: 8-bit registers in 32-bit slots, byte address = printed offset
// Notes:   Offsets of clock and event registers are local choices inside the window
package clk_ctrl_pkg;
   // Register window
   localparam logic [9:0] win_last_a         = 10'h374;
   localparam logic [9:0] own_last_a         = 10'h24c;
   localparam logic [9:0] other_first_a      = 10'h2a0;
   localparam logic [9:0] core_setup_a       = 10'h000;
   localparam logic [9:0] bit_setup_a        = 10'h004;
   localparam logic [9:0] spdif_setup_a      = 10'h008;
   localparam logic [9:0] aux_setup_a        = 10'h00c;
   localparam logic [9:0] serial_setup_a     = 10'h010;
   localparam logic [9:0] latched_flags_a    = 10'h020;
   localparam logic [9:0] live_flags_a       = 10'h024;
   localparam logic [9:0] latched_mask_a     = 10'h028;
   localparam logic [9:0] live_mask_a        = 10'h02c;
   localparam logic [9:0] analog_mult_a      = 10'h2a0;
   localparam logic [9:0] clk_status_a       = 10'h030;
   // Fields
   localparam int         sleep_bit          = 7;
   localparam int         gate_bit           = 7;
   localparam int         bclk_in_bit        = 0;
   localparam int         slave_bit          = 1;
   localparam int         halve_bit          = 0;
   localparam int         reg_w              = 8;
   localparam int         div_w              = 7;
   // Reset values
   localparam logic [7:0] core_setup_rst     = 8'h00;
   localparam logic [7:0] bit_setup_rst      = 8'h17;
   localparam logic [7:0] spdif_setup_rst    = 8'h0b;
   localparam logic [7:0] aux_setup_rst      = 8'h11;
   localparam logic [7:0] zero8              = 8'h00;
   // Clock figures
   localparam real        mult_clk_mhz       = 67.7376;
   localparam int         mult_factor        = 8;
   localparam int         halve_factor       = 2;
   localparam logic [2:0] core_max_sel       = 3'h4;
endpackage : clk_ctrl_pkg

// ### clk_div_if.sv
// Purpose: Carries one divider's control and its enable result
// Assumes: Single clock domain
// Notes:   One instance per derived clock
interface clk_div_if;
   logic [6:0] ratio;
   logic       run;
   logic       tick;
   logic       level;
   modport ctl (output ratio, output run, input tick, input level);
   modport div (input ratio, input run, output tick, output level);
endinterface : clk_div_if

// ### clk_div.sv
// Purpose: Glitch-free programmable divider producing an enable and a 50 % level
// Assumes: ratio = half period minus one, in source cycles
// Notes:   New ratio only taken at a period boundary
module clk_div (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic src_en,
   // Control
   clk_div_if.div    d
);
   logic [6:0] cnt_r;
   logic [6:0] ratio_r;
   logic       lvl_r;
   logic       tick_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r   <= 7'h00;
         ratio_r <= 7'h00;
         lvl_r   <= 1'b0;
         tick_r  <= 1'b0;
      end else begin
         tick_r <= 1'b0;
         if (!d.run) begin
            // Stop only on a low phase so no runt high remains
            if (src_en && lvl_r) begin
               if (cnt_r >= ratio_r) begin
                  cnt_r <= 7'h00;
                  lvl_r <= 1'b0;
               end else begin
                  cnt_r <= cnt_r + 7'h01;
               end
            end
            if (!lvl_r) begin
               cnt_r   <= 7'h00;
               ratio_r <= d.ratio;
            end
         end else if (src_en) begin
            if (cnt_r >= ratio_r) begin
               cnt_r <= 7'h00;
               lvl_r <= !lvl_r;
               if (!lvl_r) begin
                  tick_r <= 1'b1;
               end
               if (lvl_r) begin
                  ratio_r <= d.ratio;
               end
            end else begin
               cnt_r <= cnt_r + 7'h01;
            end
         end
      end
   end

   assign d.tick  = tick_r;
   assign d.level = lvl_r;
endmodule : clk_div

// ### clk_irq_ctrl_props.sv
// Purpose: Port-level checks of the clock and event control block
// Assumes: One clock domain; masks and sleep change only through writes
// Notes:   Mask and sleep copies are rebuilt here from the write port
module clk_irq_ctrl_props #(
   parameter int ev_w = 8
) (
   // Clock, reset and register port
   input  wire logic            clk,
   input  wire logic            rst_b,
   input  wire logic [9:0]      addr,
   input  wire logic [31:0]     wdata,
   input  wire logic            wr,
   input  wire logic            rd,
   input  wire logic [31:0]     rdata,
   // Sources and results
   input  wire logic [ev_w-1:0] live_src,
   input  wire logic [5:0]      rf_sample,
   input  wire logic [5:0]      rf_sample_q,
   input  wire logic            core_en,
   input  wire logic            audio_en,
   input  wire logic            rf_sample_clock_en,
   input  wire logic            irq_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [ev_w-1:0] lat_m_r;
   logic [ev_w-1:0] live_m_r;
   logic            sleep_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lat_m_r  <= '0;
         live_m_r <= '0;
         sleep_r  <= 1'b0;
      end else if (wr) begin
         if (addr == clk_ctrl_pkg::latched_mask_a) lat_m_r <= wdata[ev_w-1:0];
         if (addr == clk_ctrl_pkg::live_mask_a) live_m_r <= wdata[ev_w-1:0];
         if (addr == clk_ctrl_pkg::core_setup_a) sleep_r <= wdata[7];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   a_upper_zero:
      assert property (rdata[31:8] == 24'h000000) else $error("rdata upper bits set");
   a_idle_zero:
      assert property (!rd |=> rdata == 32'h0) else $error("rdata not zero without read");
   a_outside_zero:
      assert property (rd && addr > clk_ctrl_pkg::win_last_a |=> rdata == 32'h0)
         else $error("read outside window not zero");
   a_sample_tick:
      assert property (rf_sample_clock_en) else $error("sample enable dropped");
   a_sample_copy:
      assert property (1'b1 |=> rf_sample_q == $past(rf_sample)) else $error("sample lost");
   a_core_gap:
      assert property (core_en |=> !core_en) else $error("core enable too close");
   a_audio_gap:
      assert property (audio_en |=> !audio_en) else $error("audio enable too long");
   a_irq_masked:
      assert property ((lat_m_r == '0 && live_m_r == '0) [*3] |-> irq_b)
         else $error("irq with all masks off");
   a_irq_live:
      assert property ((|(live_src & live_m_r)) [*4] |-> !irq_b) else $error("irq missing");
   a_sleep_stop:
      assert property (sleep_r [*4] |-> !core_en) else $error("core enable in sleep");

   c_irq: cover property (!irq_b);
   c_flag_read: cover property (rd && addr == clk_ctrl_pkg::latched_flags_a);
   c_sleep: cover property (sleep_r && !core_en);
endmodule : clk_irq_ctrl_props

bind clk_irq_ctrl clk_irq_ctrl_props #(.ev_w(ev_w)) i_props (
   .clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .live_src, .rf_sample,
   .rf_sample_q, .core_en, .audio_en, .rf_sample_clock_en, .irq_b
);

// ### host_model.sv
// Purpose: Processor-side model driving the register strobe port
// Assumes: One access at a time, strobes one cycle long
// Notes:   Released address and data show the inverse of the last value
module host_model (
   // Clock
   input  wire logic        clk,
   // Register port
   output logic      [9:0]  addr,
   output logic      [31:0] wdata,
   output logic             wr,
   output logic             rd,
   input  wire logic [31:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr  = 10'h000;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   task automatic write_reg(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      addr  <= ~a;
      wdata <= ~d;
      // Let the written register settle before the caller looks at outputs
      #1;
   endtask : write_reg
   task automatic read_reg(input logic [9:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask : read_reg
endmodule : host_model

// ### testbench.sv
// Purpose: Self-checking bench for the clock and event control block
// Assumes: 100 MHz clock, host model drives the register port
// Notes:   Divider periods are measured between enable pulses
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, wr, rd, bit_clk_in, core_en, audio_en, spdif_en;
   logic        bit_clk_out, spdif_enable, crystal_halving_select, irq_b;
   logic [9:0]  addr;
   logic [31:0] wdata, rdata;
   logic [7:0]  latched_src, live_src;
   logic [5:0]  rf_sample;
   int          miscompares, n_compared, n;

   clk_irq_ctrl i_dut (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata, .latched_src,
      .live_src, .rf_sample, .rf_sample_q(), .core_en, .audio_en, .spdif_en,
      .rf_sample_clock_en(), .bit_clk_out, .spdif_enable, .debug_monitor_clock(),
      .external_dac_clock(), .crystal_halving_select, .bit_clk_in, .irq_b);
   host_model i_host (.clk, .addr, .wdata, .wr, .rd, .rdata);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) rf_sample <= rf_sample + 6'h01;

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic rchk(input string what, input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] d;
      i_host.read_reg(a, d);
      check(what, d, exp);
   endtask : rchk
   task automatic pulse(input logic [7:0] v);
      @(posedge clk);
      latched_src <= v;
      @(posedge clk);
      latched_src <= 8'h00;
      repeat (5) @(posedge clk);
      #1;
   endtask : pulse
   // Third interval after a change is fully at the new ratio
   task automatic period(input int k, output int n);
      for (int j = 0; j < 3; j++) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (!{spdif_en, audio_en, core_en}[k] && n < 400);
      end
   endtask : period
   task automatic results;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   initial begin
      #100us;
      miscompares++;
      results();
   end

   initial begin
      logic [9:0] ra [5] = '{clk_ctrl_pkg::core_setup_a, clk_ctrl_pkg::bit_setup_a,
         clk_ctrl_pkg::spdif_setup_a, clk_ctrl_pkg::aux_setup_a, clk_ctrl_pkg::live_mask_a};
      logic [7:0] rv [5] = '{8'h00, 8'h17, 8'h0b, 8'h11, 8'h00};
      miscompares = 0;
      n_compared  = 0;
      rst_b       = 1'b0;
      latched_src = 8'h00;
      live_src    = 8'h00;
      rf_sample   = 6'h00;
      bit_clk_in  = 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      for (int j = 0; j < 5; j++) rchk("reset value", ra[j], {24'h0, rv[j]});
      $display("test reset done");
      i_host.write_reg(clk_ctrl_pkg::aux_setup_a, 32'hffffff5a);
      rchk("aux setup", clk_ctrl_pkg::aux_setup_a, 32'h5a);
      i_host.write_reg(10'h250, 32'hffffffff);
      rchk("gap slot", 10'h250, 32'h0);
      rchk("above window", 10'h3fc, 32'h0);
      i_host.write_reg(clk_ctrl_pkg::analog_mult_a, 32'h1);
      rchk("analog slot", clk_ctrl_pkg::analog_mult_a, 32'h1);
      check("halving select", 32'(crystal_halving_select), 32'h1);
      $display("test bus done");
      for (int s = 0; s < 5; s++) begin
         i_host.write_reg(clk_ctrl_pkg::core_setup_a, 32'(s));
         period(0, n);
         check("core period", n, 32'(2 << s));
         rchk("active sel", clk_ctrl_pkg::clk_status_a, 32'(s << 1));
      end
      i_host.write_reg(clk_ctrl_pkg::core_setup_a, 32'h5);
      rchk("sel kept", clk_ctrl_pkg::clk_status_a, 32'h8);
      i_host.write_reg(clk_ctrl_pkg::core_setup_a, 32'h84);
      rchk("sleep status", clk_ctrl_pkg::clk_status_a, 32'h9);
      i_host.write_reg(clk_ctrl_pkg::core_setup_a, 32'h0);
      i_host.write_reg(clk_ctrl_pkg::bit_setup_a, 32'h83);
      rchk("bit setup", clk_ctrl_pkg::bit_setup_a, 32'h83);
      i_host.write_reg(clk_ctrl_pkg::bit_setup_a, 32'h03);
      period(1, n);
      check("bit period", n, 32'h8);
      i_host.write_reg(clk_ctrl_pkg::serial_setup_a, 32'h2);
      check("spdif on", 32'(spdif_enable), 32'h1);
      i_host.write_reg(clk_ctrl_pkg::spdif_setup_a, 32'h5);
      period(2, n);
      check("spdif period", n, 32'hc);
      $display("test clocks done");
      i_host.write_reg(clk_ctrl_pkg::serial_setup_a, 32'h1);
      check("spdif off", 32'(spdif_enable), 32'h0);
      check("bit out idle", 32'(bit_clk_out), 32'h0);
      n = 0;
      for (int j = 0; j < 48; j++) begin
         @(posedge clk);
         bit_clk_in <= j[2] && j < 40;
         #1;
         n += audio_en;
      end
      check("external edges", n, 32'h5);
      i_host.write_reg(clk_ctrl_pkg::serial_setup_a, 32'h0);
      $display("test external done");
      pulse(8'h04);
      check("irq masked", 32'(irq_b), 32'h1);
      rchk("latched flags", clk_ctrl_pkg::latched_flags_a, 32'h4);
      rchk("flags cleared", clk_ctrl_pkg::latched_flags_a, 32'h0);
      i_host.write_reg(clk_ctrl_pkg::latched_mask_a, 32'h04);
      pulse(8'h04);
      check("irq raised", 32'(irq_b), 32'h0);
      rchk("latched again", clk_ctrl_pkg::latched_flags_a, 32'h4);
      repeat (3) @(posedge clk);
      #1;
      check("irq after clear", 32'(irq_b), 32'h1);
      i_host.write_reg(clk_ctrl_pkg::live_mask_a, 32'h10);
      live_src <= 8'h10;
      repeat (5) @(posedge clk);
      #1;
      check("irq live", 32'(irq_b), 32'h0);
      rchk("live flags", clk_ctrl_pkg::live_flags_a, 32'h10);
      live_src <= 8'h00;
      repeat (4) @(posedge clk);
      rchk("live cleared", clk_ctrl_pkg::live_flags_a, 32'h0);
      check("irq idle", 32'(irq_b), 32'h1);
      $display("test events done");
      results();
   end
endmodule : testbench
